// *** rtl/rgt_pkg.sv ***
/*
 * Constants and types for the refresh granularity tracker.
 * Assumes a 100 MHz command clock shared with the memory controller.
 */
package rgt_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam int CLK_PERIOD_NS = 10;
   localparam int REFI_BASE_NS  = 7800;
   localparam int RFC1_NS       = 350;
   localparam int RFC2_NS       = 260;
   localparam int RFC4_NS       = 160;
   // Interval is a longest time: round down; cycle times are least: round up
   localparam int REFI_BASE_CYC = REFI_BASE_NS / CLK_PERIOD_NS;
   localparam int RFC1_CYC      = (RFC1_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RFC2_CYC      = (RFC2_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RFC4_CYC      = (RFC4_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int INTV_W        = 10;
   localparam int RFC_W         = 6;

   ////////////////////////////////////////////////////////////////////////////
   // Granularity field of mode register three and its field positions
   localparam int         GRAN_OTF_BIT   = 2;
   localparam int         GRAN_QUAD_BIT  = 1;
   localparam logic [2:0] GRAN_FIX_1X    = 3'h0;
   localparam logic [2:0] GRAN_FIX_2X    = 3'h1;
   localparam logic [2:0] GRAN_FIX_4X    = 3'h2;
   localparam logic [2:0] GRAN_OTF_1X2X  = 3'h5;
   localparam logic [2:0] GRAN_OTF_1X4X  = 3'h6;
   localparam logic [2:0] GRAN_RESET     = GRAN_FIX_1X;

   // Rate index: also the interval shift of that rate
   localparam logic [1:0] RATE_1X = 2'h0;
   localparam logic [1:0] RATE_2X = 2'h1;
   localparam logic [1:0] RATE_4X = 2'h2;

   localparam logic [2:0] EXTRA_1X = 3'h1;
   localparam logic [2:0] EXTRA_2X = 3'h2;
   localparam logic [2:0] EXTRA_4X = 3'h4;

   typedef enum logic [0:0] {
      ST_RUN  = 1'b0,
      ST_SELF = 1'b1
   } rgt_state_t;

   // One command cycle towards the memory device
   typedef struct packed {
      logic       refresh;
      logic       bankGroupBitZero;
      logic       modeWrite;
      logic [2:0] modeCode;
      logic       selfRefEnter;
      logic       selfRefExit;
   } rgt_cmd_t;
endpackage : rgt_pkg

// *** rtl/rgt_refresh_tracker.sv ***
/*
 * Refresh scheduler and granularity tracker on the controller side.
 * Assumes all requests come from logic on clk_sys and that devCmd is
 * turned into bus commands one cycle later by the command encoder.
 */
module rgt_refresh_tracker (
   // Clock and reset
   input  wire logic            clk_sys,
   input  wire logic            reset_n,
   // Requests from the controller core
   input  wire logic [2:0]      modeCode,
   input  wire logic            modeWrReq,
   input  wire logic            tcrEnable,
   input  wire logic [1:0]      tempBand,
   input  wire logic            preferNormal,
   input  wire logic            srEnterReq,
   input  wire logic            srExitReq,
   // Command to the memory device and status
   output rgt_pkg::rgt_cmd_t    devCmd,
   output logic                 modeWrRefused,
   output logic                 inSelfRefresh
);
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [rgt_pkg::INTV_W-1:0] refiCycles(input logic [1:0] rate,
                                                             input logic [1:0] band);
      logic [2:0] sh;
      sh = {1'b0, rate} + {1'b0, band};
      refiCycles = rgt_pkg::INTV_W'(rgt_pkg::REFI_BASE_CYC >> sh);
   endfunction : refiCycles

   function automatic logic [rgt_pkg::RFC_W-1:0] rfcLoad(input logic [1:0] rate);
      case (rate)
         rgt_pkg::RATE_2X: rfcLoad = rgt_pkg::RFC_W'(rgt_pkg::RFC2_CYC - 1);
         rgt_pkg::RATE_4X: rfcLoad = rgt_pkg::RFC_W'(rgt_pkg::RFC4_CYC - 1);
         default:          rfcLoad = rgt_pkg::RFC_W'(rgt_pkg::RFC1_CYC - 1);
      endcase
   endfunction : rfcLoad

   function automatic logic [1:0] rateOf(input logic [2:0] code);
      rateOf = code[rgt_pkg::GRAN_QUAD_BIT] ? rgt_pkg::RATE_4X :
               (code[0] ? rgt_pkg::RATE_2X : rgt_pkg::RATE_1X);
   endfunction : rateOf

   function automatic logic codeLegal(input logic [2:0] code);
      codeLegal = (code == rgt_pkg::GRAN_FIX_1X) || (code == rgt_pkg::GRAN_FIX_2X) ||
                  (code == rgt_pkg::GRAN_FIX_4X) || (code == rgt_pkg::GRAN_OTF_1X2X) ||
                  (code == rgt_pkg::GRAN_OTF_1X4X);
   endfunction : codeLegal

   ////////////////////////////////////////////////////////////////////////////
   rgt_pkg::rgt_state_t         state_reg;
   rgt_pkg::rgt_cmd_t           cmd_reg;
   logic [2:0]                  gran_reg;
   logic [2:0]                  modeNext_reg;
   logic                        modePend_reg;
   logic                        srEnterPend_reg;
   logic                        srExitPend_reg;
   logic                        duePend_reg;
   logic                        refused_reg;
   logic [1:0]                  residue_reg;
   logic [2:0]                  owedAtEntry_reg;
   logic [2:0]                  extraCnt_reg;
   logic [rgt_pkg::INTV_W-1:0]  intv_reg;
   logic [rgt_pkg::RFC_W-1:0]   rfc_reg;

   logic [1:0] curRate;
   logic       otfMode;
   logic       aligned;
   logic       canIssue;
   logic       sameRate;
   logic       doExtra;
   logic       doRef;
   logic       doMode;
   logic       doSrEnter;
   logic       doSrExit;
   logic       issueNormal;
   logic [1:0] issueRate;
   logic [2:0] owed;

   assign curRate  = rateOf(gran_reg);
   assign otfMode  = gran_reg[rgt_pkg::GRAN_OTF_BIT];
   // Fixed normal rate never leaves a residue
   assign aligned  = (curRate == rgt_pkg::RATE_4X) ? (residue_reg == 2'h0)
                                                    : (residue_reg[0] == 1'b0);
   assign canIssue = (state_reg == rgt_pkg::ST_RUN) && (rfc_reg == '0);
   assign sameRate = rateOf(modeNext_reg) == curRate;

   // Extras first so the obligation is cleared before routine traffic
   assign doExtra   = canIssue && (extraCnt_reg != 3'h0);
   assign doRef     = canIssue && !doExtra && duePend_reg;
   // Rate change by mode write only on a whole-refresh boundary
   assign doMode    = canIssue && !doExtra && !duePend_reg && modePend_reg &&
                      (sameRate || aligned);
   assign doSrEnter = canIssue && !doExtra && !duePend_reg && !modePend_reg &&
                      srEnterPend_reg;
   assign doSrExit  = (state_reg == rgt_pkg::ST_SELF) && srExitPend_reg;

   // Normal refresh in ON_THE_FLY_SELECT only when the fine count is aligned
   assign issueNormal = (curRate == rgt_pkg::RATE_1X) ||
                        (otfMode && (doExtra || (preferNormal && aligned)));
   assign issueRate   = issueNormal ? rgt_pkg::RATE_1X : curRate;

   always_comb begin
      if (aligned) begin
         owed = 3'h0;
      end else if (otfMode) begin
         owed = rgt_pkg::EXTRA_1X;
      end else if (curRate == rgt_pkg::RATE_4X) begin
         owed = rgt_pkg::EXTRA_4X;
      end else begin
         owed = rgt_pkg::EXTRA_2X;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Self refresh state
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= rgt_pkg::ST_RUN;
      end else if (doSrEnter) begin
         state_reg <= rgt_pkg::ST_SELF;
      end else if (doSrExit) begin
         state_reg <= rgt_pkg::ST_RUN;
      end
   end

   // Pending requests; only an entry request in the clearing cycle is kept: a mode request is refused, an exit request dropped
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         modePend_reg    <= 1'b0;
         modeNext_reg    <= rgt_pkg::GRAN_RESET;
         refused_reg     <= 1'b0;
         srEnterPend_reg <= 1'b0;
         srExitPend_reg  <= 1'b0;
      end else begin
         refused_reg <= 1'b0;
         if (modeWrReq && !modePend_reg) begin
            if (!codeLegal(modeCode) || (tcrEnable && modeCode != rgt_pkg::GRAN_FIX_1X)) begin
               refused_reg <= 1'b1;
            end else begin
               modePend_reg <= 1'b1;
               modeNext_reg <= modeCode;
            end
         end else if (modeWrReq) begin
            refused_reg <= 1'b1;
         end else if (doMode) begin
            modePend_reg <= 1'b0;
         end
         if (srEnterReq) begin
            srEnterPend_reg <= 1'b1;
         end else if (doSrEnter) begin
            srEnterPend_reg <= 1'b0;
         end
         if (srExitReq && state_reg == rgt_pkg::ST_SELF && !doSrExit) begin
            srExitPend_reg <= 1'b1;
         end else if (doSrExit) begin
            srExitPend_reg <= 1'b0;
         end
      end
   end

   // Granularity now in force
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gran_reg <= rgt_pkg::GRAN_RESET;
      end else if (doMode) begin
         gran_reg <= modeNext_reg;
      end
   end

   // Fine-rate residue and the extra obligation after exit
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         residue_reg     <= 2'h0;
         owedAtEntry_reg <= 3'h0;
         extraCnt_reg    <= 3'h0;
      end else begin
         if ((doMode && !sameRate) || doSrExit) begin
            residue_reg <= 2'h0;
         end else if ((doRef || doExtra) && issueNormal) begin
            residue_reg <= 2'h0;
         end else if (doRef || doExtra) begin
            residue_reg <= residue_reg + 2'h1;
         end
         if (doSrEnter) begin
            owedAtEntry_reg <= owed;
         end
         if (doSrExit) begin
            extraCnt_reg <= owedAtEntry_reg;
         end else if (doExtra) begin
            extraCnt_reg <= extraCnt_reg - 3'h1;
         end
      end
   end

   // Average interval timer; extras do not reload it
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         intv_reg    <= rgt_pkg::INTV_W'(rgt_pkg::REFI_BASE_CYC);
         duePend_reg <= 1'b0;
      end else begin
         if (doRef) begin
            intv_reg <= refiCycles(issueRate, tempBand);
         end else if (doMode &&
                      (refiCycles(rateOf(modeNext_reg), tempBand) < intv_reg)) begin
            // Only shorten: a full reload would stretch the gap past one interval
            intv_reg <= refiCycles(rateOf(modeNext_reg), tempBand);
         end else if (doSrExit) begin
            intv_reg <= refiCycles(curRate, tempBand);
         end else if (state_reg == rgt_pkg::ST_RUN && intv_reg != '0) begin
            intv_reg <= intv_reg - rgt_pkg::INTV_W'(1);
         end
         if (state_reg == rgt_pkg::ST_RUN && intv_reg == '0 && !doRef) begin
            duePend_reg <= 1'b1;
         end else if (doRef || doSrExit) begin
            duePend_reg <= 1'b0;
         end
      end
   end

   // Refresh cycle time guard
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rfc_reg <= '0;
      end else if (doRef || doExtra) begin
         rfc_reg <= rfcLoad(issueRate);
      end else if (rfc_reg != '0) begin
         rfc_reg <= rfc_reg - rgt_pkg::RFC_W'(1);
      end
   end

   // Command register
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         cmd_reg <= '0;
      end else begin
         cmd_reg.refresh          <= doRef || doExtra;
         cmd_reg.bankGroupBitZero <= (doRef || doExtra) && !issueNormal;
         cmd_reg.modeWrite        <= doMode;
         cmd_reg.modeCode         <= doMode ? modeNext_reg : gran_reg;
         cmd_reg.selfRefEnter     <= doSrEnter;
         cmd_reg.selfRefExit      <= doSrExit;
      end
   end

   assign devCmd        = cmd_reg;
   assign modeWrRefused = refused_reg;
   assign inSelfRefresh = state_reg == rgt_pkg::ST_SELF;
endmodule : rgt_refresh_tracker

// *** dv/rgt_dram_model.sv ***
/*
 * Behavioural memory device that watches the tracker's command stream.
 * Assumes devCmd is sampled on the rising edge of clk_sys.
 */
module rgt_dram_model (
   // Clock and reset
   input  wire logic              clk_sys,
   input  wire logic              reset_n,
   // Commands from the tracker
   input  wire rgt_pkg::rgt_cmd_t devCmd,
   // Observed refreshes and faults
   output logic [15:0]            refCount,
   output logic [7:0]             errCount
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [2:0] gran;
   logic       selfRef;
   logic       bad;
   int         busy;
   ////////////////////////////////////////
   // A device cannot take a refresh or mode write mid-refresh or while self refreshing
   assign bad = ((devCmd.refresh || devCmd.modeWrite) && (busy > 1 || selfRef))
      || (devCmd.modeWrite && !(devCmd.modeCode inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6}));
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         gran     <= rgt_pkg::GRAN_RESET;
         selfRef  <= 1'b0;
         busy     <= 0;
         refCount <= 16'h0000;
         errCount <= 8'h00;
      end else begin
         errCount <= errCount + 8'(bad);
         if (devCmd.modeWrite) gran <= devCmd.modeCode;
         if (devCmd.selfRefEnter) selfRef <= 1'b1;
         if (devCmd.selfRefExit) selfRef <= 1'b0;
         if (devCmd.refresh) begin
            refCount <= refCount + 16'h0001;
            busy <= !devCmd.bankGroupBitZero ? rgt_pkg::RFC1_CYC
               : gran[rgt_pkg::GRAN_QUAD_BIT] ? rgt_pkg::RFC4_CYC : rgt_pkg::RFC2_CYC;
         end else if (busy > 0) busy <= busy - 1;
      end
   end
endmodule : rgt_dram_model

// *** dv/rgt_refresh_tracker_assertions.sv ***
/*
 * Protocol checker for the refresh granularity tracker.
 * Assumes it is bound to the tracker's top ports.
 */
module rgt_refresh_tracker_assertions (
   // Clock and reset
   input wire logic              clk_sys,
   input wire logic              reset_n,
   // Requests
   input wire logic [2:0]        modeCode,
   input wire logic              modeWrReq,
   input wire logic              tcrEnable,
   // Results
   input wire rgt_pkg::rgt_cmd_t devCmd,
   input wire logic              modeWrRefused,
   input wire logic              inSelfRefresh
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking dc @(posedge clk_sys);
   endclocking
   default disable iff (!reset_n);
   logic [5:0] rfcGap, rfcNeed;
   logic [9:0] sinceRef;
   logic [2:0] curCode;
   logic [1:0] residue, entryRes;
   wire logic  fine = devCmd.refresh && devCmd.bankGroupBitZero;
   function automatic logic [1:0] rateOf(input logic [2:0] c);
      return c[0] ? rgt_pkg::RATE_2X : c[1] ? rgt_pkg::RATE_4X : rgt_pkg::RATE_1X;
   endfunction : rateOf
   function automatic logic aligned(input logic [1:0] r, input logic [2:0] c);
      return rateOf(c) == rgt_pkg::RATE_4X ? r == 2'h0 :
             rateOf(c) == rgt_pkg::RATE_2X ? !r[0] : 1'b1;
   endfunction : aligned
   ////////////////////////////////////////
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         rfcGap  <= 6'h3f;
         rfcNeed <= 6'h00;
      end else if (devCmd.refresh) begin
         rfcGap  <= 6'h00;
         rfcNeed <= !fine ? 6'(rgt_pkg::RFC1_CYC) : devCmd.modeCode[rgt_pkg::GRAN_QUAD_BIT]
            ? 6'(rgt_pkg::RFC4_CYC) : 6'(rgt_pkg::RFC2_CYC);
      end else if (rfcGap != 6'h3f) rfcGap <= rfcGap + 6'h01;
   end
   // Self refresh time is not interval time
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) sinceRef <= 10'h000;
      else sinceRef <= (devCmd.refresh || inSelfRefresh) ? 10'h000 : sinceRef + 10'h001;
   end
   always_ff @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         curCode  <= rgt_pkg::GRAN_RESET;
         residue  <= 2'h0;
         entryRes <= 2'h0;
      end else begin
         if (devCmd.modeWrite) curCode <= devCmd.modeCode;
         if (devCmd.selfRefEnter) entryRes <= residue;
         if ((devCmd.refresh && !fine) || devCmd.selfRefExit
            || (devCmd.modeWrite && rateOf(devCmd.modeCode) != rateOf(curCode))) residue <= 2'h0;
         else if (fine) residue <= residue + 2'h1;
      end
   end
   ////////////////////////////////////////
   sequence s_bad_req;
      modeWrReq && (modeCode inside {3'h3, 3'h4, 3'h7} || (tcrEnable && modeCode != 3'h0));
   endsequence
   sequence s_exit_owing;
      devCmd.selfRefExit && !aligned(entryRes, curCode);
   endsequence
   property p_rfc_gap;
      devCmd.refresh |-> rfcGap >= rfcNeed - 6'h01;
   endproperty
   a_rfc_gap: assert property (p_rfc_gap) else $error("refresh inside cycle time");
   property p_rfc_mode;
      devCmd.modeWrite |-> rfcGap >= rfcNeed - 6'h01;
   endproperty
   a_rfc_mode: assert property (p_rfc_mode) else $error("mode write inside cycle time");
   property p_interval;
      !inSelfRefresh |-> sinceRef <= 10'(rgt_pkg::REFI_BASE_CYC + 8);
   endproperty
   a_interval: assert property (p_interval) else $error("refresh interval overrun");
   property p_bg0_only;
      devCmd.bankGroupBitZero |-> devCmd.refresh;
   endproperty
   a_bg0_only: assert property (p_bg0_only) else $error("rate bit without refresh");
   property p_fixed_type;
      devCmd.refresh && !devCmd.modeCode[rgt_pkg::GRAN_OTF_BIT]
         |-> devCmd.bankGroupBitZero == (devCmd.modeCode != rgt_pkg::GRAN_FIX_1X);
   endproperty
   a_fixed_type: assert property (p_fixed_type) else $error("wrong refresh type");
   property p_rate_change;
      devCmd.modeWrite && rateOf(devCmd.modeCode) != rateOf(curCode) |-> aligned(residue, curCode);
   endproperty
   a_rate_change: assert property (p_rate_change) else $error("rate change unaligned");
   property p_otf_between;
      devCmd.refresh && !fine && curCode[rgt_pkg::GRAN_OTF_BIT] |-> aligned(residue, curCode);
   endproperty
   a_otf_between: assert property (p_otf_between) else $error("normal refresh unaligned");
   property p_legal;
      devCmd.modeWrite |-> devCmd.modeCode inside {3'h0, 3'h1, 3'h2, 3'h5, 3'h6};
   endproperty
   a_legal: assert property (p_legal) else $error("reserved code written");
   property p_refuse;
      s_bad_req |-> ##[1:2] modeWrRefused;
   endproperty
   a_refuse: assert property (p_refuse) else $error("bad mode request not refused");
   property p_extra;
      s_exit_owing |=> devCmd.refresh;
   endproperty
   a_extra: assert property (p_extra) else $error("no extra refresh after exit");
endmodule : rgt_refresh_tracker_assertions

// *** dv/rgt_refresh_tracker_tb.sv ***
/*
 * Random and directed test of the refresh granularity tracker.
 * Assumes the device model and checker are compiled before it.
 */
module rgt_refresh_tracker_tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic              clk_sys, reset_n, modeWrReq, tcrEnable, preferNormal, srEnterReq, srExitReq;
   logic [2:0]        modeCode;
   logic [1:0]        tempBand;
   rgt_pkg::rgt_cmd_t devCmd;
   logic              modeWrRefused, inSelfRefresh;
   logic [15:0]       refCount;
   logic [7:0]        errCount;
   logic [2:0]        badCodes [5] = '{3'h3, 3'h4, 3'h7, 3'h1, 3'h6};
   logic [2:0]        srCodes [4] = '{3'h1, 3'h2, 3'h5, 3'h6};
   int                fail_count, total_checks, n, k, base, lo;
   rgt_refresh_tracker rgt_refresh_tracker_i (.clk_sys(clk_sys), .reset_n(reset_n),
      .modeCode(modeCode), .modeWrReq(modeWrReq), .tcrEnable(tcrEnable), .tempBand(tempBand),
      .preferNormal(preferNormal), .srEnterReq(srEnterReq), .srExitReq(srExitReq),
      .devCmd(devCmd), .modeWrRefused(modeWrRefused), .inSelfRefresh(inSelfRefresh));
   rgt_dram_model rgt_dram_model_i (.clk_sys(clk_sys), .reset_n(reset_n), .devCmd(devCmd),
      .refCount(refCount), .errCount(errCount));
   initial begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   ////////////////////////////////////////
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("Error at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic int expExtras(input logic [2:0] c, input int r);
      return c[0] ? ((r % 2) ? (c[2] ? 1 : 2) : 0) : ((r % 4) ? (c[2] ? 1 : 4) : 0);
   endfunction : expExtras
   // Bounded wait for one event; a timeout shows up as a mismatch
   task automatic waitFor(input int sel, input int limit, output int cycles);
      logic [4:0] ev;
      cycles = 0;
      do begin
         @(negedge clk_sys);
         cycles++;
         ev = {devCmd.selfRefExit, devCmd.selfRefEnter, modeWrRefused, devCmd.modeWrite,
            devCmd.refresh};
      end while (ev[sel] !== 1'b1 && cycles < limit);
      check(16'(ev[sel]), 16'h0001);
   endtask : waitFor
   task automatic pulse(input int sel, input logic [2:0] code);
      modeCode = code;
      {srExitReq, srEnterReq, modeWrReq} = 3'(1 << sel);
      @(negedge clk_sys);
      {srExitReq, srEnterReq, modeWrReq} = 3'b000;
   endtask : pulse
   task automatic final_report();
      $display("Checks %0d, mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : final_report
   ////////////////////////////////////////
   initial begin
      {modeWrReq, tcrEnable, preferNormal, srEnterReq, srExitReq, modeCode, tempBand} = 10'h000;
      reset_n = 1'b0;
      void'($urandom(32'h7a566126));
      repeat (5) @(negedge clk_sys);
      check(16'({devCmd, modeWrRefused, inSelfRefresh}), 16'h0000);
      reset_n = 1'b1;
      for (int i = 0; i < 5; i++) begin
         tcrEnable = i > 2;
         pulse(0, badCodes[i]);
         // The refusal stands in the cycle in which the request is dropped
         check(16'(modeWrRefused), 16'h0001);
         @(negedge clk_sys);
      end
      pulse(0, 3'h0);
      waitFor(1, 2000, n);
      tcrEnable = 1'b0;
      for (int c = 0; c < 3; c++) begin
         tempBand = 2'($urandom_range(3));
         pulse(0, 3'(c));
         waitFor(1, 2000, n);
         check(16'(devCmd.modeCode), 16'(c));
         repeat (3) waitFor(0, 2000, n);
         lo = rgt_pkg::REFI_BASE_CYC >> (c + int'(tempBand));
         check(16'(n >= lo && n <= lo + 3), 16'h0001);
         check(16'(devCmd.bankGroupBitZero), 16'(c != 0));
      end
      tempBand = 2'h0;
      for (int i = 0; i < 4; i++) begin
         pulse(0, 3'h0);
         waitFor(1, 3000, n);
         pulse(0, srCodes[i]);
         waitFor(1, 3000, n);
         k = $urandom_range(3);
         repeat (k) begin
            waitFor(0, 1000, n);
            check(16'(devCmd.bankGroupBitZero), 16'h0001);
         end
         pulse(1, 3'h0);
         waitFor(3, 100, n);
         check(16'(inSelfRefresh), 16'h0001);
         repeat (20) @(negedge clk_sys);
         pulse(2, 3'h0);
         waitFor(4, 4, n);
         check(16'(inSelfRefresh), 16'h0000);
         base = refCount;
         repeat (100) @(negedge clk_sys);
         check(refCount - 16'(base), 16'(expExtras(srCodes[i], k)));
      end
      preferNormal = 1'b1;
      pulse(0, 3'h5);
      waitFor(1, 3000, n);
      waitFor(0, 1000, n);
      check(16'(devCmd.bankGroupBitZero), 16'h0000);
      check(16'(errCount), 16'h0000);
      final_report();
   end
   initial begin
      repeat (100000) @(posedge clk_sys);
      fail_count++;
      final_report();
   end
endmodule : rgt_refresh_tracker_tb
bind rgt_refresh_tracker rgt_refresh_tracker_assertions rgt_refresh_tracker_assertions_i (
   .clk_sys(clk_sys), .reset_n(reset_n), .modeCode(modeCode), .modeWrReq(modeWrReq),
   .tcrEnable(tcrEnable), .devCmd(devCmd), .modeWrRefused(modeWrRefused),
   .inSelfRefresh(inSelfRefresh));
